// [rtl/tgu_pkg.sv]
// Constants, register map and encodings for the trigger gate and action block.
// Assumes a 40 MHz aclk and 16-bit converted analog samples.
package tgu_pkg;
   localparam int unsigned TGU_CLK_HZ = 40000000;
   localparam int unsigned TGU_ADC_W = 16;
   localparam int unsigned TGU_CHR_W = 32;
   localparam int unsigned TGU_NUNITS = 4;

   // Register byte offsets, one per unit block of 0x10 plus globals
   localparam logic [7:0] TGU_OFS_CTRL = 8'h00;
   localparam logic [7:0] TGU_OFS_STAT = 8'h04;
   localparam logic [7:0] TGU_OFS_CHRON = 8'h08;
   localparam logic [7:0] TGU_OFS_LATCH = 8'h0C;
   localparam logic [7:0] TGU_OFS_TPER = 8'h10;
   localparam logic [7:0] TGU_OFS_UNIT0 = 8'h20;
   localparam logic [7:0] TGU_OFS_USTRIDE = 8'h10;
   localparam logic [7:0] TGU_OFS_UCFG = 8'h00;
   localparam logic [7:0] TGU_OFS_UTHR = 8'h04;
   localparam logic [7:0] TGU_OFS_UPW = 8'h08;

   // Control register fields
   localparam int unsigned TGU_CTRL_SHOT_LSB = 0;
   localparam int unsigned TGU_CTRL_REL_BIT = 4;
   localparam int unsigned TGU_CTRL_OUTCLR_BIT = 5;

   // Unit config fields
   localparam int unsigned TGU_CFG_SRC_LSB = 0;
   localparam int unsigned TGU_CFG_EVT_LSB = 4;
   localparam int unsigned TGU_CFG_EN_LSB = 8;
   localparam int unsigned TGU_CFG_ACT_LSB = 12;
   localparam int unsigned TGU_FLD_W = 3;

   typedef enum logic [2:0] {
      TGU_SRC_SHOT = 3'h0, TGU_SRC_TIMER = 3'h1, TGU_SRC_DIN = 3'h2,
      TGU_SRC_AIN1 = 3'h3, TGU_SRC_AIN2 = 3'h4, TGU_SRC_CHAIN = 3'h5
   } tgu_src_t;

   typedef enum logic [2:0] {
      TGU_EVT_RISE = 3'h0, TGU_EVT_FALL = 3'h1, TGU_EVT_PLONG = 3'h2,
      TGU_EVT_PSHORT = 3'h3, TGU_EVT_NLONG = 3'h4, TGU_EVT_NSHORT = 3'h5
   } tgu_evt_t;

   typedef enum logic [2:0] {
      TGU_EN_ALWAYS = 3'h0, TGU_EN_DIN_HI = 3'h1, TGU_EN_AIN1_HI = 3'h2,
      TGU_EN_AIN2_HI = 3'h3, TGU_EN_DIN_LO = 3'h4, TGU_EN_AIN1_LO = 3'h5,
      TGU_EN_AIN2_LO = 3'h6
   } tgu_en_t;

   typedef enum logic [2:0] {
      TGU_ACT_NONE = 3'h0, TGU_ACT_ZERO = 3'h1, TGU_ACT_LATCH = 3'h2,
      TGU_ACT_SETOUT = 3'h3, TGU_ACT_START = 3'h4, TGU_ACT_ARMNEXT = 3'h5
   } tgu_act_t;

   localparam logic [31:0] TGU_TPER_RST = 32'h0000_0000;
   localparam logic [15:0] TGU_PW_RST = 16'h0000;
   localparam logic [15:0] TGU_THR_RST = 16'h0000;
endpackage

// [rtl/tgu_unit.sv]
// One trigger unit: source pick, event detect, enable gate, action decode.
// Assumes synchronised inputs and sample strobes on the same aclk.
module tgu_unit
   import tgu_pkg::*;
#(
   parameter int unsigned PW_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] src_sel,
   input wire logic [2:0] evt_sel,
   input wire logic [2:0] en_sel,
   input wire logic [2:0] act_sel,
   input wire logic [PW_W-1:0] pulse_width,
   input wire logic two_ch,
   input wire logic shot,
   input wire logic timer_tick,
   input wire logic din,
   input wire logic ain1_above,
   input wire logic ain2_above,
   input wire logic chain_in,
   output logic act_zero,
   output logic act_latch,
   output logic act_setout,
   output logic act_start,
   output logic act_next
);
   typedef struct packed {
      logic lvl;
      logic [PW_W-1:0] wcnt;
      logic zero;
      logic latch;
      logic setout;
      logic start;
      logic next;
   } tgu_ust_t;

   tgu_ust_t st_r;
   tgu_ust_t st_nxt;

   logic lvl_now;
   logic fire;
   logic en_ok;
   logic gated;
   logic long_w;

   always_comb begin
      // Event-type sources are pulses; level sources feed the edge logic
      case (src_sel)
         TGU_SRC_SHOT: lvl_now = shot;
         TGU_SRC_TIMER: lvl_now = timer_tick;
         TGU_SRC_DIN: lvl_now = din;
         TGU_SRC_AIN1: lvl_now = ain1_above;
         TGU_SRC_AIN2: lvl_now = two_ch & ain2_above;
         TGU_SRC_CHAIN: lvl_now = chain_in;
         default: lvl_now = 1'b0;
      endcase
   end

   assign long_w = (st_r.wcnt >= pulse_width);

   always_comb begin
      case (evt_sel)
         TGU_EVT_RISE: fire = lvl_now & ~st_r.lvl;
         TGU_EVT_FALL: fire = ~lvl_now & st_r.lvl;
         TGU_EVT_PLONG: fire = ~lvl_now & st_r.lvl & long_w;
         TGU_EVT_PSHORT: fire = ~lvl_now & st_r.lvl & ~long_w;
         TGU_EVT_NLONG: fire = lvl_now & ~st_r.lvl & long_w;
         TGU_EVT_NSHORT: fire = lvl_now & ~st_r.lvl & ~long_w;
         default: fire = lvl_now & ~st_r.lvl;
      endcase
   end

   always_comb begin
      case (en_sel)
         TGU_EN_ALWAYS: en_ok = 1'b1;
         TGU_EN_DIN_HI: en_ok = din;
         TGU_EN_DIN_LO: en_ok = ~din;
         TGU_EN_AIN1_HI: en_ok = ain1_above;
         TGU_EN_AIN2_HI: en_ok = two_ch & ain2_above;
         TGU_EN_AIN1_LO: en_ok = ~ain1_above;
         TGU_EN_AIN2_LO: en_ok = two_ch & ~ain2_above;
         default: en_ok = 1'b0;
      endcase
   end

   assign gated = fire & en_ok;

   always_comb begin
      st_nxt = st_r;
      st_nxt.lvl = lvl_now;
      // Width counter saturates so long pulses never wrap to short
      if (lvl_now != st_r.lvl) begin
         st_nxt.wcnt = '0;
      end else if (st_r.wcnt != '1) begin
         st_nxt.wcnt = st_r.wcnt + 1'b1;
      end
      // One action pulse per gated event
      st_nxt.zero = gated && (act_sel == TGU_ACT_ZERO);
      st_nxt.latch = gated && (act_sel == TGU_ACT_LATCH);
      st_nxt.setout = gated && (act_sel == TGU_ACT_SETOUT);
      st_nxt.start = gated && (act_sel == TGU_ACT_START);
      st_nxt.next = gated && (act_sel == TGU_ACT_ARMNEXT);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign act_zero = st_r.zero;
   assign act_latch = st_r.latch;
   assign act_setout = st_r.setout;
   assign act_start = st_r.start;
   assign act_next = st_r.next;
endmodule

// [rtl/tgu_top.sv]
// File holds the AXI4-Lite register slave, chronometer and four units.
// Assumes analog samples arrive with a one-cycle strobe on aclk.
module tgu_top
   import tgu_pkg::*;
#(
   parameter int unsigned ADC_W = TGU_ADC_W,
   parameter int unsigned CHR_W = TGU_CHR_W,
   parameter bit TWO_CH = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic trig_in,
   input wire logic [ADC_W-1:0] analog_channel_one,
   input wire logic [ADC_W-1:0] analog_channel_two,
   input wire logic sample_stb,
   output logic digital_out,
   output logic record_start
);
   localparam int unsigned NU = TGU_NUNITS;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   typedef struct packed {
      logic awr;
      logic [7:0] awa;
      logic wr;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
      logic [3:0] shot;
      logic release_en;
      logic dout;
      logic rec;
      logic [1:0] din_s;
      logic [31:0] tper;
      logic [31:0] tcnt;
      logic tick;
      logic [CHR_W-1:0] chron;
      logic [CHR_W-1:0] latch;
      logic [NU-1:0] a1_hi;
      logic [NU-1:0] a2_hi;
      logic [NU-1:0][15:0] cfg;
      logic [NU-1:0][ADC_W-1:0] thr;
      logic [NU-1:0][15:0] pw;
   } tgu_st_t;

   tgu_st_t st_r;
   tgu_st_t st_nxt;

   logic [NU-1:0] a_zero, a_latch, a_set, a_start, a_next;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] fld(input logic [15:0] c,
                                      input int unsigned lsb);
      return c[lsb +: TGU_FLD_W];
   endfunction

   // Units exist only in pairs; units three and four on two-channel parts
   function automatic logic unit_hit(input logic [7:0] a, output int u,
                                     output logic [7:0] ofs);
      logic [7:0] rel;
      rel = a - TGU_OFS_UNIT0;
      u = int'(rel[5:4]);
      ofs = {4'h0, rel[3:0]};
      return (a >= TGU_OFS_UNIT0) &&
             (rel < TGU_OFS_USTRIDE * 8'(TWO_CH ? NU : NU / 2));
   endfunction

   genvar g;
   generate
      for (g = 0; g < NU; g++) begin : g_unit
         tgu_unit #(.PW_W(16)) u_unit (
            .aclk(aclk),
            .aresetn(aresetn),
            .src_sel(fld(st_r.cfg[g], TGU_CFG_SRC_LSB)),
            .evt_sel(fld(st_r.cfg[g], TGU_CFG_EVT_LSB)),
            .en_sel(fld(st_r.cfg[g], TGU_CFG_EN_LSB)),
            .act_sel(fld(st_r.cfg[g], TGU_CFG_ACT_LSB)),
            .pulse_width(st_r.pw[g]),
            .two_ch(TWO_CH),
            .shot(st_r.shot[g]),
            .timer_tick(st_r.tick),
            .din(st_r.din_s[1]),
            .ain1_above(st_r.a1_hi[g]),
            .ain2_above(st_r.a2_hi[g]),
            // Unit one has no predecessor
            .chain_in((g == 0) ? 1'b0 : a_next[(g == 0) ? 0 : g-1]),
            .act_zero(a_zero[g]),
            .act_latch(a_latch[g]),
            .act_setout(a_set[g]),
            .act_start(a_start[g]),
            .act_next(a_next[g])
         );
      end
   endgenerate

   always_comb begin
      int u;
      logic [7:0] ofs;
      logic hit;
      logic [31:0] v;
      u = 0;
      ofs = 8'h00;
      hit = 1'b0;
      v = 32'h0000_0000;
      st_nxt = st_r;
      st_nxt.shot = '0;
      st_nxt.din_s = {st_r.din_s[0], trig_in};

      // Timer source: period zero disables the tick
      st_nxt.tick = 1'b0;
      if (st_r.tper != TGU_TPER_RST) begin
         if (st_r.tcnt >= st_r.tper - 32'h0000_0001) begin
            st_nxt.tcnt = 32'h0000_0000;
            st_nxt.tick = 1'b1;
         end else begin
            st_nxt.tcnt = st_r.tcnt + 32'h0000_0001;
         end
      end

      // Compare only on a fresh sample, so results hold between samples
      if (sample_stb) begin
         for (int k = 0; k < NU; k++) begin
            st_nxt.a1_hi[k] = analog_channel_one > st_r.thr[k];
            st_nxt.a2_hi[k] = analog_channel_two > st_r.thr[k];
         end
      end

      // Chronometer: zero wins over counting, then restarts at once
      if (|a_zero) begin
         st_nxt.chron = '0;
      end else begin
         st_nxt.chron = st_r.chron + 1'b1;
      end
      if (|a_latch) begin
         st_nxt.latch = st_r.chron;
      end
      if (|a_set && st_r.release_en) begin
         st_nxt.dout = 1'b1;
      end
      st_nxt.rec = |a_start;

      // AXI write channels, taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.awr = 1'b0;
         st_nxt.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.wr = 1'b0;
         st_nxt.wd = s_axi_wdata;
         st_nxt.ws = s_axi_wstrb;
      end
      if (!st_r.awr && !st_r.wr && !st_r.bv) begin
         st_nxt.bv = 1'b1;
         st_nxt.br = RESP_OK;
         hit = unit_hit(st_r.awa, u, ofs);
         if ({st_r.awa[7:2], 2'b00} == TGU_OFS_CTRL) begin
            v = merge(32'h0000_0000, st_r.wd, st_r.ws);
            st_nxt.shot = v[TGU_CTRL_SHOT_LSB +: NU];
            st_nxt.release_en = v[TGU_CTRL_REL_BIT];
            // Clearing output is skipped when a set arrives in the same cycle and the write sets release
            if (v[TGU_CTRL_OUTCLR_BIT] && !(|a_set && v[TGU_CTRL_REL_BIT])) begin
               st_nxt.dout = 1'b0;
            end
         end else if ({st_r.awa[7:2], 2'b00} == TGU_OFS_TPER) begin
            st_nxt.tper = merge(st_r.tper, st_r.wd, st_r.ws);
            st_nxt.tcnt = 32'h0000_0000;
         end else if (hit && ofs[3:2] == TGU_OFS_UCFG[3:2]) begin
            v = merge({16'h0000, st_r.cfg[u]}, st_r.wd, st_r.ws);
            st_nxt.cfg[u] = v[15:0];
         end else if (hit && ofs[3:2] == TGU_OFS_UTHR[3:2]) begin
            v = merge(32'(st_r.thr[u]), st_r.wd, st_r.ws);
            st_nxt.thr[u] = v[ADC_W-1:0];
         end else if (hit && ofs[3:2] == TGU_OFS_UPW[3:2]) begin
            v = merge({16'h0000, st_r.pw[u]}, st_r.wd, st_r.ws);
            st_nxt.pw[u] = v[15:0];
         end else begin
            st_nxt.br = RESP_ERR;
         end
      end
      if (st_r.bv && s_axi_bready) begin
         st_nxt.bv = 1'b0;
         st_nxt.awr = 1'b1;
         st_nxt.wr = 1'b1;
      end

      // AXI read: one cycle to answer, arready low while rvalid stands
      if (s_axi_arvalid && !st_r.rv) begin
         st_nxt.rv = 1'b1;
         st_nxt.rr = RESP_OK;
         st_nxt.rd = 32'h0000_0000;
         hit = unit_hit(s_axi_araddr, u, ofs);
         case ({s_axi_araddr[7:2], 2'b00})
            TGU_OFS_CTRL: st_nxt.rd[TGU_CTRL_REL_BIT] = st_r.release_en;
            TGU_OFS_STAT: st_nxt.rd = {28'h0000000, st_r.rec, st_r.dout,
                                       st_r.din_s[1], 1'b0};
            TGU_OFS_CHRON: st_nxt.rd = 32'(st_r.chron);
            TGU_OFS_LATCH: st_nxt.rd = 32'(st_r.latch);
            TGU_OFS_TPER: st_nxt.rd = st_r.tper;
            default: begin
               if (hit && ofs[3:2] == TGU_OFS_UCFG[3:2]) begin
                  st_nxt.rd = {16'h0000, st_r.cfg[u]};
               end else if (hit && ofs[3:2] == TGU_OFS_UTHR[3:2]) begin
                  st_nxt.rd = 32'(st_r.thr[u]);
               end else if (hit && ofs[3:2] == TGU_OFS_UPW[3:2]) begin
                  st_nxt.rd = {16'h0000, st_r.pw[u]};
               end else begin
                  st_nxt.rr = RESP_ERR;
               end
            end
         endcase
      end else if (st_r.rv && s_axi_rready) begin
         st_nxt.rv = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.awr <= 1'b1;
         st_r.wr <= 1'b1;
         st_r.tper <= TGU_TPER_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = st_r.awr;
   assign s_axi_wready = st_r.wr;
   assign s_axi_bvalid = st_r.bv;
   assign s_axi_bresp = st_r.br;
   assign s_axi_arready = ~st_r.rv;
   assign s_axi_rvalid = st_r.rv;
   assign s_axi_rdata = st_r.rd;
   assign s_axi_rresp = st_r.rr;
   assign digital_out = st_r.dout;
   assign record_start = st_r.rec;
endmodule

// [sim/tgu_chk_assertions.sv]
// Checker for the trigger gate block: bus handshakes and action outputs.
// Assumes it is bound to tgu_top and sees only the ports named below.
module tgu_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic digital_out,
   input wire logic record_start
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   AST_WR_ANSWER: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   AST_B_HOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   AST_B_DONE: assert property (
      s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not reopened");
   AST_R_HOLD: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer not held");
   AST_AR_READY: assert property (
      s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
   AST_RD_ANSWER: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_START_PULSE: assert property (
      record_start |=> !record_start) else $error("start longer than 1");
   AST_OUT_CLEAR: assert property (
      $fell(digital_out)
      |-> !s_axi_awready || !$past(s_axi_awready) || !$past(aresetn))
      else $error("output cleared without a write");
endmodule

bind tgu_top tgu_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .digital_out, .record_start);

// [sim/tgu_ctl_model.sv]
// Controller model: AXI4-Lite master that configures the trigger units.
// Assumes wr and rd are called from one process at a time.
module tgu_ctl_model (
   input wire logic aclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
   end
   // Ready comes late at random so stalled answers get exercised
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      repeat ($urandom_range(2)) @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      repeat ($urandom_range(2)) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// [sim/tb_trigger_unit_gate_and_action.sv]
// Self-checking bench for the trigger gate and action block.
// Assumes the controller model drives the bus; the bench drives the pins.
module tb_trigger_unit_gate_and_action
   import tgu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, digital_out, record_start;
   logic trig_in = 1'b0;
   logic sample_stb = 1'b0;
   logic [15:0] ain1 = 16'h0;
   logic [15:0] ain2 = 16'h0;
   logic rel = 1'b0;
   int n_errors = 0;
   int tests_run = 0;
   int n_rec = 0;

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) if (record_start) n_rec <= n_rec + 1;

   tgu_top #(.TWO_CH(1'b1)) dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_in,
      .analog_channel_one(ain1), .analog_channel_two(ain2), .sample_stb,
      .digital_out, .record_start);
   tgu_ctl_model ctl (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);

   function automatic logic [7:0] ucfg(int u);
      return TGU_OFS_UNIT0 + 8'(u) * TGU_OFS_USTRIDE;
   endfunction
   function automatic logic [31:0] cfg(logic [2:0] s, logic [2:0] ev,
                                       logic [2:0] en, logic [2:0] a);
      return {17'h0, a, 1'b0, en, 1'b0, ev, 1'b0, s};
   endfunction
   // Below means not above, so equal values count as below
   function automatic bit en_ok(int en, bit d, logic [15:0] x,
                                logic [15:0] y, logic [15:0] t);
      case (en)
         0: return 1'b1;
         1: return d;
         2: return x > t;
         3: return y > t;
         4: return !d;
         5: return !(x > t);
         default: return !(y > t);
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL t=%0t resp got=%h exp=%h", $time, got, exp);
      end
   endtask
   // New sample, then junk without strobe: compares must keep the sample
   task automatic set_in(input logic d, input logic [15:0] x,
                         input logic [15:0] y);
      @(posedge aclk);
      trig_in <= d;
      ain1 <= x;
      ain2 <= y;
      sample_stb <= 1'b1;
      @(posedge aclk);
      sample_stb <= 1'b0;
      ain1 <= ~x;
      ain2 <= ~y;
      repeat (6) @(posedge aclk);
   endtask
   task automatic fire(input int u, input int exp);
      logic [1:0] r;
      int n0;
      n0 = n_rec;
      ctl.wr(TGU_OFS_CTRL, {26'h0, 1'b0, rel, 4'(1 << u)}, r);
      repeat (16) @(posedge aclk);
      chk(32'(n_rec - n0), 32'(exp));
   endtask
   task automatic final_report();
      $display("Counts: %0d compared, %0d mismatched", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Tests need about 1200 cycles; hang limit well beyond
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      final_report();
   end

   initial begin
      logic [31:0] v, c0, c1;
      logic [1:0] rsp;
      logic [15:0] thr, x, y;
      bit d;
      int n0;
      void'($urandom(32'hBFA16082));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      ctl.rd(TGU_OFS_TPER, v, rsp);
      chk(v, TGU_TPER_RST);
      ctl.wr(TGU_OFS_TPER, 32'h0000_0123, rsp);
      chk_rsp(rsp, 2'h0);
      ctl.rd(TGU_OFS_TPER, v, rsp);
      chk(v, 32'h0000_0123);
      chk_rsp(rsp, 2'h0);
      ctl.wr(TGU_OFS_TPER, TGU_TPER_RST, rsp);
      ctl.rd(8'h14, v, rsp);
      chk_rsp(rsp, 2'h2);
      ctl.wr(8'h14, 32'hFFFF_FFFF, rsp);
      chk_rsp(rsp, 2'h2);
      $display("register test done");
      for (int en = 0; en < 7; en++) begin
         thr = 16'($urandom);
         ctl.wr(ucfg(0) + TGU_OFS_UTHR, {16'h0, thr}, rsp);
         ctl.wr(ucfg(0), cfg(TGU_SRC_SHOT, TGU_EVT_RISE, 3'(en),
                TGU_ACT_START), rsp);
         for (int k = 0; k < 4; k++) begin
            d = 1'($urandom);
            x = (k == 0) ? thr : 16'($urandom);
            y = (k == 1) ? thr : 16'($urandom);
            set_in(d, x, y);
            fire(0, en_ok(en, d, x, y, thr));
         end
      end
      $display("enable test done");
      ctl.wr(ucfg(0), cfg(TGU_SRC_SHOT, TGU_EVT_RISE, TGU_EN_ALWAYS,
             TGU_ACT_ARMNEXT), rsp);
      for (int u = 1; u < 4; u++)
         ctl.wr(ucfg(u), cfg(TGU_SRC_CHAIN, TGU_EVT_RISE, TGU_EN_ALWAYS,
                (u == 3) ? TGU_ACT_START : TGU_ACT_ARMNEXT), rsp);
      fire(0, 1);
      ctl.wr(ucfg(2), cfg(TGU_SRC_CHAIN, TGU_EVT_RISE, TGU_EN_DIN_HI,
             TGU_ACT_ARMNEXT), rsp);
      set_in(1'b0, 16'h0, 16'h0);
      fire(0, 0);
      $display("chain test done");
      ctl.wr(ucfg(1), cfg(TGU_SRC_SHOT, TGU_EVT_RISE, TGU_EN_ALWAYS,
             TGU_ACT_LATCH), rsp);
      ctl.rd(TGU_OFS_CHRON, c0, rsp);
      fire(1, 0);
      ctl.rd(TGU_OFS_CHRON, c1, rsp);
      ctl.rd(TGU_OFS_LATCH, v, rsp);
      chk(32'(v > c0 && v < c1), 32'h1);
      ctl.wr(ucfg(1), cfg(TGU_SRC_SHOT, TGU_EVT_RISE, TGU_EN_ALWAYS,
             TGU_ACT_ZERO), rsp);
      fire(1, 0);
      ctl.rd(TGU_OFS_CHRON, c0, rsp);
      ctl.rd(TGU_OFS_CHRON, c1, rsp);
      chk(32'(c0 < 32'h40), 32'h1);
      chk(32'(c1 > c0), 32'h1);
      ctl.wr(ucfg(1), cfg(TGU_SRC_SHOT, TGU_EVT_RISE, TGU_EN_ALWAYS,
             TGU_ACT_SETOUT), rsp);
      fire(1, 0);
      chk(32'(digital_out), 32'h0);
      rel = 1'b1;
      fire(1, 0);
      chk(32'(digital_out), 32'h1);
      ctl.rd(TGU_OFS_STAT, v, rsp);
      chk(32'(v[2]), 32'h1);
      ctl.wr(TGU_OFS_CTRL, 32'h0000_0030, rsp);
      repeat (2) @(posedge aclk);
      chk(32'(digital_out), 32'h0);
      $display("action test done");
      for (int ev = 0; ev < 2; ev++) begin
         ctl.wr(ucfg(2), cfg(TGU_SRC_DIN, 3'(ev), TGU_EN_ALWAYS,
                TGU_ACT_START), rsp);
         n0 = n_rec;
         set_in(1'b1, 16'h0, 16'h0);
         chk(32'(n_rec - n0), 32'(ev == 0));
         n0 = n_rec;
         set_in(1'b0, 16'h0, 16'h0);
         chk(32'(n_rec - n0), 32'(ev == 1));
      end
      $display("source test done");
      final_report();
   end
endmodule
